// file: bench/tb.sv
/* Self-checking bench of usbe_ep_regs with an APB master.
 * Uses usbe_host_model for the engine side and the bound checker. */
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb
    import usbe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [2:0] ep; logic [7:0] wv; usbe_tok_e t; logic [5:0] n;
        logic ok; logic tg; usbe_resp_e r; logic [7:0] nm; logic irq;
    } usbe_step_s;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, resp_valid, ep0_fifo_wr_block, er;
    logic        eng_setup_start, eng_hs_start, eng_tok_valid;
    logic        eng_rx_crc_ok, eng_rx_toggle;
    usbe_tok_e   eng_tok_type;
    usbe_resp_e  resp;
    logic [2:0]  eng_tok_ep;
    logic [5:0]  eng_rx_count;
    logic [4:0]  ep_irq;
    logic [7:0]  rd;
    int          err_count = 0, checks = 0;
    usbe_step_s  st [16] = '{
        '{0, 8'h01, TOK_SETUP, 6'h0A, 1, 0, RESP_ACK, 8'h91, 1},
        '{0, 8'h01, TOK_SETUP, 6'h0C, 1, 0, RESP_IGNORE, 8'h81, 1},
        '{0, 8'h01, TOK_SETUP, 6'h04, 0, 0, RESP_IGNORE, 8'h81, 1},
        '{0, 8'h0B, TOK_OUT, 6'h04, 1, 1, RESP_ACK, 8'h3A, 1},
        '{0, 8'h0B, TOK_IN, 6'h00, 1, 0, RESP_ZLP, 8'h5B, 1},
        '{0, 8'h0A, TOK_OUT, 6'h04, 1, 1, RESP_NAK, 8'h2A, 1},
        '{0, 8'h0A, TOK_OUT, 6'h04, 0, 1, RESP_IGNORE, 8'h0A, 0},
        '{0, 8'h06, TOK_OUT, 6'h04, 1, 1, RESP_STALL, 8'h23, 1},
        '{0, 8'h06, TOK_IN, 6'h00, 1, 0, RESP_ZLP, 8'h56, 1},
        '{0, 8'h0F, TOK_OUT, 6'h02, 1, 1, RESP_ACK, 8'h3F, 1},
        '{0, 8'h0F, TOK_OUT, 6'h02, 1, 0, RESP_STALL, 8'h23, 1},
        '{0, 8'h0F, TOK_IN, 6'h00, 1, 0, RESP_ACK, 8'h5E, 1},
        '{1, 8'h8D, TOK_OUT, 6'h04, 1, 0, RESP_STALL, 8'h8D, 0},
        '{1, 8'h0D, TOK_IN, 6'h00, 1, 0, RESP_DATA, 8'h1D, 1},
        '{2, 8'h09, TOK_OUT, 6'h06, 1, 1, RESP_ACK, 8'h19, 1},
        '{0, 8'h01, TOK_IN, 6'h00, 1, 0, RESP_NAK, 8'h41, 1}};
    usbe_ep_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb(4'hF), .pready, .prdata, .pslverr, .eng_setup_start,
        .eng_hs_start, .eng_tok_valid, .eng_tok_type, .eng_tok_ep,
        .eng_rx_count, .eng_rx_crc_ok, .eng_rx_toggle, .resp_valid, .resp,
        .ep_irq, .ep0_fifo_wr_block);
    usbe_host_model host (.pclk, .eng_setup_start, .eng_hs_start,
        .eng_tok_valid, .eng_tok_type, .eng_tok_ep, .eng_rx_count,
        .eng_rx_crc_ok, .eng_rx_toggle);
    always #5 pclk = ~pclk;
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] idx,
        input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite} <= {1'b1, 1'b0, w};
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        rd = prdata[7:0];
        er = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 20) begin err_count++; wrap_up(); end
    endtask
    initial begin
        #500us err_count++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(0, CNT_IDX[i], 0); `CHK("cnt_rst", CNT_RESET, rd)
            apb(0, MODE_IDX[i], 0); `CHK("mode_rst", MODE_RESET, rd)
        end
        apb(0, 8'h40, 0); `CHK("unmapped", 1'b1, er)
        apb(1, IDX_EP1_MODE, 8'hFF);
        apb(0, IDX_EP1_MODE, 0); `CHK("ep1_mode", 8'h9F, rd)
        apb(1, IDX_EP3_CNT, 8'h20);
        apb(0, IDX_EP3_CNT, 0); `CHK("ep3_cnt", 8'h20, rd)
        $display("register test done");
        apb(1, IDX_EP0_MODE, 8'h01);
        host.send(TOK_SETUP, 0, 6'h0A, 1, 0);
        #1 `CHK("fifo_block", 1'b1, ep0_fifo_wr_block)
        apb(1, IDX_EP0_CNT, 8'h00);
        apb(0, IDX_EP0_CNT, 0); `CHK("cnt_lock", 8'h4A, rd)
        apb(1, IDX_EP0_MODE, 8'h0B);
        apb(0, IDX_EP0_MODE, 0); `CHK("mode_lock", 8'h11, rd)
        apb(1, IDX_EP0_MODE, 8'h0B);
        apb(0, IDX_EP0_MODE, 0); `CHK("unlock", 8'h0B, rd)
        $display("locking test done");
        foreach (st[i]) begin
            apb(0, MODE_IDX[st[i].ep], 0);
            apb(1, MODE_IDX[st[i].ep], st[i].wv);
            host.send(st[i].t, st[i].ep, st[i].n, st[i].ok, st[i].tg);
            #1 `CHK("resp", st[i].r, resp)
            `CHK("irq", st[i].irq, ep_irq[st[i].ep])
            apb(0, MODE_IDX[st[i].ep], 0);
            `CHK("mode", st[i].nm, rd)
        end
        $display("mode table test done");
        wrap_up();
    end
endmodule

// file: bench/usbe_ep_regs_properties.sv
/* Port assertions of the endpoint mode and count registers.
 * Bound to usbe_ep_regs; needs usbe_pkg compiled first. */
module usbe_ep_regs_properties
    import usbe_pkg::*;
(
    input wire logic        pclk,             // Clock.
    input wire logic        presetn,          // Reset, low.
    input wire logic        psel,             // Select.
    input wire logic        penable,          // Access phase.
    input wire logic        pwrite,           // Write.
    input wire logic [31:0] prdata,           // Read data.
    input wire logic        eng_setup_start,  // SETUP data.
    input wire logic        eng_tok_valid,    // Update point.
    input wire usbe_tok_e   eng_tok_type,     // Token.
    input wire logic [2:0]  eng_tok_ep,       // Endpoint.
    input wire logic        resp_valid,       // Answer.
    input wire logic [4:0]  ep_irq,           // Interrupts.
    input wire logic        ep0_fifo_wr_block // Buffer block.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RESP_LAT: assert property (
        eng_tok_valid && eng_tok_ep == 3'h0 |=> resp_valid)
        else $error("answer missing after update point");
    AST_RESP_NONE: assert property (
        !eng_tok_valid |=> !resp_valid)
        else $error("answer without update point");
    AST_IRQ_RESP: assert property (
        ep_irq != 5'h00 |-> resp_valid && $onehot(ep_irq))
        else $error("interrupt outside answer");
    AST_IRQ_EP: assert property (
        ep_irq != 5'h00 |-> ep_irq == (5'h01 << $past(eng_tok_ep)))
        else $error("interrupt on wrong endpoint");
    AST_BLK_SET: assert property (
        eng_setup_start |=> ep0_fifo_wr_block)
        else $error("buffer not blocked on SETUP");
    AST_BLK_RISE: assert property (
        $rose(ep0_fifo_wr_block) |-> $past(eng_setup_start
            || eng_tok_valid && eng_tok_type == TOK_SETUP))
        else $error("setup flag set without SETUP");
    AST_BLK_HOLD: assert property (
        ep0_fifo_wr_block && !(psel && penable && pwrite)
            |=> ep0_fifo_wr_block)
        else $error("setup flag lost without write");
    AST_UPPER: assert property (
        psel && penable |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
endmodule
bind usbe_ep_regs usbe_ep_regs_properties u_props (.pclk, .presetn,
    .psel, .penable, .pwrite, .prdata, .eng_setup_start, .eng_tok_valid,
    .eng_tok_type, .eng_tok_ep, .resp_valid, .ep_irq, .ep0_fifo_wr_block);

// file: bench/usbe_host_model.sv
/* Upstream host as seen through the serial engine's event pulses.
 * Driven from the bench's process via the send task on pclk. */
module usbe_host_model
    import usbe_pkg::*;
(
    input  wire logic  pclk,            // Clock.
    output logic       eng_setup_start, // SETUP data.
    output logic       eng_hs_start,    // Handshake.
    output logic       eng_tok_valid,   // Update point.
    output usbe_tok_e  eng_tok_type,    // Token.
    output logic [2:0] eng_tok_ep,      // Endpoint.
    output logic [5:0] eng_rx_count,    // Bytes plus CRC.
    output logic       eng_rx_crc_ok,   // CRC good.
    output logic       eng_rx_toggle    // Toggle.
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {eng_setup_start, eng_hs_start, eng_tok_valid} = 3'h0;
        {eng_tok_ep, eng_rx_count, eng_rx_crc_ok, eng_rx_toggle} = 11'h0;
        eng_tok_type = TOK_IN;
    end
    task automatic send(input usbe_tok_e t, input logic [2:0] ep,
        input logic [5:0] n, input logic ok, input logic tg);
        if (t == TOK_SETUP) begin
            @(posedge pclk) eng_setup_start <= 1'b1;
            @(posedge pclk) eng_setup_start <= 1'b0;
            @(posedge pclk) eng_hs_start <= 1'b1;
            @(posedge pclk) eng_hs_start <= 1'b0;
        end
        @(posedge pclk);
        eng_tok_valid <= 1'b1;
        eng_tok_type <= t;
        eng_tok_ep <= ep;
        eng_rx_count <= n;
        eng_rx_crc_ok <= ok;
        eng_rx_toggle <= tg;
        @(posedge pclk);
        eng_tok_valid <= 1'b0;
        eng_rx_count <= ~n;
        eng_rx_crc_ok <= ~ok;
        eng_rx_toggle <= ~tg;
    endtask
endmodule

// file: hdl/usbe_ctl_resp.sv
/*
 * Decision table of the control endpoint: given its mode and the packet
 * just received, what the engine answers and which fields it changes.
 * Purely combinational; the caller applies the result at the update point.
 */
module usbe_ctl_resp
    import usbe_pkg::*;
(
    input  wire logic [3:0]  mode,       // Current control endpoint mode.
    input  wire usbe_tok_e   tok,        // Token type.
    input  wire logic [5:0]  rx_count,   // Received bytes plus CRC.
    input  wire logic        rx_crc_ok,  // Data CRC correct.
    input  wire logic        rx_toggle,  // Received data toggle.
    output usbe_resp_e       resp,       // Answer to the host.
    output logic             cnt_upd,    // Load toggle, valid and count.
    output logic             set_setup,  // Set the setup flag.
    output logic             set_in,     // Set the IN flag.
    output logic             set_out,    // Set the OUT flag.
    output logic             set_ack,    // Set the handshake flag.
    output logic             mode_en,    // Load a new mode.
    output logic [3:0]       mode_val,   // New mode.
    output logic             irq         // Raise the endpoint interrupt.
);
    logic short_ok;

    always_comb begin
        short_ok  = rx_crc_ok && (rx_count <= SHORT_MAX_CNT);
        resp      = RESP_IGNORE;
        cnt_upd   = 1'b0;
        set_setup = 1'b0;
        set_in    = 1'b0;
        set_out   = 1'b0;
        set_ack   = 1'b0;
        mode_en   = 1'b0;
        mode_val  = mode;
        irq       = 1'b0;
        if (tok == TOK_SETUP) begin
            if (mode != MODE_DISABLED) begin
                cnt_upd   = 1'b1;
                set_setup = 1'b1;
                irq       = 1'b1;
                if (short_ok) begin
                    set_ack  = 1'b1;
                    mode_en  = 1'b1;
                    mode_val = MODE_NAK_IO;
                    resp     = RESP_ACK;
                end
            end
        end else if (tok == TOK_IN) begin
            case (mode)
                MODE_NAK_IO, MODE_STALL_IO: begin
                    set_in = 1'b1;
                    irq    = 1'b1;
                    resp   = (mode == MODE_NAK_IO) ? RESP_NAK : RESP_STALL;
                end
                MODE_NORM_OUT, MODE_PREM_STAT, MODE_STAT_IN: begin
                    set_in  = 1'b1;
                    set_ack = 1'b1;
                    irq     = 1'b1;
                    resp    = RESP_ZLP;
                end
                MODE_STAT_OUT, MODE_STAT_OUTB: begin
                    set_in   = 1'b1;
                    set_ack  = 1'b1;
                    irq      = 1'b1;
                    resp     = RESP_ACK;
                    mode_en  = (mode == MODE_STAT_OUT);
                    mode_val = MODE_STAT_OUTB;
                end
                default: resp = RESP_IGNORE;
            endcase
        end else if (tok == TOK_OUT) begin
            case (mode)
                MODE_NAK_IO, MODE_STALL_IO: begin
                    set_out = 1'b1;
                    irq     = 1'b1;
                    resp    = (mode == MODE_NAK_IO) ? RESP_NAK : RESP_STALL;
                end
                MODE_NORM_OUT: begin
                    cnt_upd = 1'b1;
                    set_out = 1'b1;
                    irq     = 1'b1;
                    if (short_ok) begin
                        set_ack  = 1'b1;
                        mode_en  = 1'b1;
                        mode_val = MODE_PREM_STAT;
                        resp     = RESP_ACK;
                    end
                end
                MODE_PREM_STAT: begin
                    if (short_ok) begin
                        set_out = 1'b1;
                        irq     = 1'b1;
                        resp    = RESP_NAK;
                    end
                end
                MODE_STAT_IN: begin
                    if (short_ok) begin
                        set_out  = 1'b1;
                        irq      = 1'b1;
                        mode_en  = 1'b1;
                        mode_val = MODE_STALL_IO;
                        resp     = RESP_STALL;
                    end
                end
                MODE_STAT_OUT, MODE_STAT_OUTB: begin
                    if (short_ok) begin
                        cnt_upd = 1'b1;
                        set_out = 1'b1;
                        irq     = 1'b1;
                        if (rx_count == STATUS_CNT && rx_toggle) begin
                            set_ack = 1'b1;
                            resp    = RESP_ACK;
                        end else begin
                            mode_en  = 1'b1;
                            mode_val = MODE_STALL_IO;
                            resp     = RESP_STALL;
                        end
                    end
                end
                default: resp = RESP_IGNORE;
            endcase
        end
    end

endmodule

// file: hdl/usbe_ep_regs.sv
/*
 * Endpoint mode and counter registers between the USB serial engine and
 * the processor, with the control endpoint's update locking.
 * Assumes an APB master on pclk and an engine on the same clock that
 * pulses its events for one cycle each.
 */
// Local design decision: the APB interface to the registers.
module usbe_ep_regs
    import usbe_pkg::*;
#(
    parameter int N_EP = NUM_EP     // Number of endpoints.
)
(
    input  wire logic              pclk,           // System clock.
    input  wire logic              presetn,        // Async reset, low.
    input  wire logic              psel,           // APB select.
    input  wire logic              penable,        // APB access phase.
    input  wire logic              pwrite,         // APB write.
    input  wire logic [11:0]       paddr,          // APB byte address.
    input  wire logic [31:0]       pwdata,         // APB write data.
    input  wire logic [3:0]        pstrb,          // APB byte strobes.
    output logic                   pready,         // APB ready.
    output logic [31:0]            prdata,         // APB read data.
    output logic                   pslverr,        // APB error.
    input  wire logic              eng_setup_start, // SETUP data begins.
    input  wire logic              eng_hs_start,   // Handshake begins.
    input  wire logic              eng_tok_valid,  // Update point pulse.
    input  wire usbe_tok_e         eng_tok_type,   // Token type.
    input  wire logic [2:0]        eng_tok_ep,     // Endpoint number.
    input  wire logic [5:0]        eng_rx_count,   // Bytes plus CRC.
    input  wire logic              eng_rx_crc_ok,  // CRC correct.
    input  wire logic              eng_rx_toggle,  // Received toggle.
    output logic                   resp_valid,     // Answer strobe.
    output usbe_resp_e             resp,           // Answer to host.
    output logic [N_EP-1:0]        ep_irq,         // Interrupt pulses.
    output logic                   ep0_fifo_wr_block // Buffer write block.
);

    // Refuse other endpoint counts while the design is elaborated.
    if (N_EP != NUM_EP) begin
        $error("usbe_ep_regs serves exactly five endpoints");
    end

    typedef struct packed {
        logic [NUM_EP-1:0][7:0] cnt;
        logic [NUM_EP-1:0][7:0] mode;
        logic                   setup_force;
        logic                   mode_lock;
        logic                   cnt_lock;
        logic                   rd_ok;
        logic [31:0]            prdata;
        logic                   pslverr;
        logic                   resp_valid;
        usbe_resp_e             resp;
        logic [NUM_EP-1:0]      irq;
    } usbe_state_s;

    usbe_state_s st_r;
    usbe_state_s st_nxt;

    usbe_resp_e  c_resp;
    logic        c_cnt_upd;
    logic        c_set_setup;
    logic        c_set_in;
    logic        c_set_out;
    logic        c_set_ack;
    logic        c_mode_en;
    logic [3:0]  c_mode_val;
    logic        c_irq;

    usbe_ctl_resp u_ctl (
        .mode      (st_r.mode[0][3:0]),
        .tok       (eng_tok_type),
        .rx_count  (eng_rx_count),
        .rx_crc_ok (eng_rx_crc_ok),
        .rx_toggle (eng_rx_toggle),
        .resp      (c_resp),
        .cnt_upd   (c_cnt_upd),
        .set_setup (c_set_setup),
        .set_in    (c_set_in),
        .set_out   (c_set_out),
        .set_ack   (c_set_ack),
        .mode_en   (c_mode_en),
        .mode_val  (c_mode_val),
        .irq       (c_irq)
    );

    logic        addr_ok;
    logic [7:0]  idx;
    logic        setup_ph;
    logic        acc_wr;
    logic        acc_rd;
    logic [7:0]  rdata;
    logic        hit;
    logic [7:0]  rx_cnt_word;
    logic        ep0_tok;
    logic        upd_mode0;
    logic        upd_cnt0;
    logic [3:0]  m;

    always_comb begin
        st_nxt      = st_r;
        idx         = paddr[9:2];
        addr_ok     = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
        setup_ph    = psel && !penable;
        acc_wr      = psel && penable && pwrite && !st_r.pslverr;
        acc_rd      = psel && penable && !pwrite && !st_r.pslverr;
        rx_cnt_word = {eng_rx_toggle, eng_rx_crc_ok, eng_rx_count};
        ep0_tok     = eng_tok_valid && (eng_tok_ep == 3'h0);
        upd_mode0   = ep0_tok && (c_set_setup || c_set_in || c_set_out ||
                      c_set_ack || c_mode_en);
        upd_cnt0    = ep0_tok && c_cnt_upd;
        rdata       = 8'h00;
        hit         = 1'b0;
        m           = 4'h0;

        // Read data is captured in the setup phase.
        for (int i = 0; i < NUM_EP; i++) begin
            if (addr_ok && idx == CNT_IDX[i]) begin
                rdata = st_r.cnt[i];
                hit   = 1'b1;
            end
            if (addr_ok && idx == MODE_IDX[i]) begin
                rdata = st_r.mode[i];
                hit   = 1'b1;
            end
        end
        if (setup_ph) begin
            st_nxt.prdata  = {24'h000000, rdata};
            st_nxt.pslverr = !hit;
            // A capture taken at an update edge holds stale values.
            st_nxt.rd_ok   = !(upd_mode0 || upd_cnt0);
        end

        // Processor reads unlock only after the update point.
        if (acc_rd && st_r.rd_ok && idx == IDX_EP0_MODE) begin
            st_nxt.mode_lock = 1'b0;
        end
        if (acc_rd && st_r.rd_ok && idx == IDX_EP0_CNT) begin
            st_nxt.cnt_lock = 1'b0;
        end

        // Processor writes.
        if (acc_wr && pstrb[0]) begin
            if (idx == IDX_EP0_MODE) begin
                if (!st_r.mode_lock) begin
                    st_nxt.mode[0][6:0] = pwdata[6:0];
                end
                if (!st_r.setup_force) begin
                    st_nxt.mode[0][BIT_SETUP] = 1'b0;
                end
            end
            if (idx == IDX_EP0_CNT && !st_r.cnt_lock) begin
                st_nxt.cnt[0] = pwdata[7:0];
            end
            for (int i = 1; i < NUM_EP; i++) begin
                if (idx == MODE_IDX[i]) begin
                    // Reserved bits are not stored and read as zero.
                    st_nxt.mode[i] = {pwdata[7], 2'b00, pwdata[4:0]};
                end
                if (idx == CNT_IDX[i]) begin
                    st_nxt.cnt[i] = pwdata[7:0];
                end
            end
        end

        // Setup flag forcing from SETUP data until the handshake.
        if (eng_setup_start) begin
            st_nxt.setup_force        = 1'b1;
            st_nxt.mode[0][BIT_SETUP] = 1'b1;
        end else if (eng_hs_start || (ep0_tok && c_set_setup)) begin
            st_nxt.setup_force = 1'b0;
        end

        // Engine update point; it wins over a same-cycle processor access.
        st_nxt.resp_valid = eng_tok_valid;
        st_nxt.resp       = RESP_IGNORE;
        st_nxt.irq        = '0;
        if (ep0_tok) begin
            st_nxt.resp = c_resp;
            if (c_cnt_upd) begin
                st_nxt.cnt[0]   = rx_cnt_word;
                st_nxt.cnt_lock = 1'b1;
            end
            if (c_set_setup) begin
                st_nxt.mode[0][BIT_SETUP] = 1'b1;
            end
            if (c_set_in) begin
                st_nxt.mode[0][BIT_IN] = 1'b1;
            end
            if (c_set_out) begin
                st_nxt.mode[0][BIT_OUT] = 1'b1;
            end
            if (c_set_ack) begin
                st_nxt.mode[0][BIT_ACK] = 1'b1;
            end
            if (c_mode_en) begin
                st_nxt.mode[0][3:0] = c_mode_val;
            end
            if (upd_mode0) begin
                st_nxt.mode_lock = 1'b1;
            end
            st_nxt.irq[0] = c_irq;
        end

        // Non-control endpoints.
        for (int i = 1; i < NUM_EP; i++) begin
            if (eng_tok_valid && eng_tok_ep == 3'(i)) begin
                m = st_r.mode[i][3:0];
                if (m == MODE_DISABLED || eng_tok_type == TOK_SETUP) begin
                    st_nxt.resp = RESP_IGNORE;
                end else if (eng_tok_type == TOK_OUT) begin
                    if (m == MODE_ACK_OUT) begin
                        st_nxt.cnt[i] = rx_cnt_word;
                        st_nxt.irq[i] = 1'b1;
                        if (eng_rx_crc_ok) begin
                            st_nxt.mode[i][BIT_ACK] = 1'b1;
                            st_nxt.resp             = RESP_ACK;
                        end
                    end else if (st_r.mode[i][BIT_STALL] &&
                                 m == MODE_ACK_IN) begin
                        st_nxt.resp = RESP_STALL;
                    end else begin
                        st_nxt.resp = RESP_NAK;
                    end
                end else begin
                    if (m == MODE_ACK_IN) begin
                        // The update point of an IN follows the host ACK.
                        st_nxt.mode[i][BIT_ACK] = 1'b1;
                        st_nxt.irq[i]           = 1'b1;
                        st_nxt.resp             = RESP_DATA;
                    end else if (st_r.mode[i][BIT_STALL] &&
                                 m == MODE_ACK_OUT) begin
                        st_nxt.resp = RESP_STALL;
                    end else begin
                        st_nxt.resp = RESP_NAK;
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r             <= '0;
            st_r.cnt         <= {NUM_EP{CNT_RESET}};
            st_r.mode        <= {NUM_EP{MODE_RESET}};
            st_r.resp        <= RESP_IGNORE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pready            = 1'b1;
    assign prdata            = st_r.prdata;
    assign pslverr           = st_r.pslverr;
    assign resp_valid        = st_r.resp_valid;
    assign resp              = st_r.resp;
    assign ep_irq            = st_r.irq;
    assign ep0_fifo_wr_block = st_r.mode[0][BIT_SETUP];

endmodule

// file: hdl/usbe_pkg.sv
/*
 * Shared constants and types of the endpoint mode and count logic.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package usbe_pkg;

    localparam int NUM_EP = 5;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_EP0_CNT  = 8'h11;
    localparam logic [7:0] IDX_EP0_MODE = 8'h12;
    localparam logic [7:0] IDX_EP1_CNT  = 8'h13;
    localparam logic [7:0] IDX_EP1_MODE = 8'h14;
    localparam logic [7:0] IDX_EP2_CNT  = 8'h15;
    localparam logic [7:0] IDX_EP2_MODE = 8'h16;
    localparam logic [7:0] IDX_EP3_CNT  = 8'h41;
    localparam logic [7:0] IDX_EP3_MODE = 8'h42;
    localparam logic [7:0] IDX_EP4_CNT  = 8'h43;
    localparam logic [7:0] IDX_EP4_MODE = 8'h44;

    localparam logic [NUM_EP-1:0][7:0] CNT_IDX = {
        IDX_EP4_CNT, IDX_EP3_CNT, IDX_EP2_CNT, IDX_EP1_CNT, IDX_EP0_CNT};
    localparam logic [NUM_EP-1:0][7:0] MODE_IDX = {
        IDX_EP4_MODE, IDX_EP3_MODE, IDX_EP2_MODE, IDX_EP1_MODE,
        IDX_EP0_MODE};

    localparam logic [7:0] CNT_RESET  = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;

    // Field positions shared by mode and counter registers.
    localparam int BIT_SETUP  = 7;
    localparam int BIT_STALL  = 7;
    localparam int BIT_IN     = 6;
    localparam int BIT_OUT    = 5;
    localparam int BIT_ACK    = 4;
    localparam int BIT_TOGGLE = 7;
    localparam int BIT_DVAL   = 6;

    localparam logic [5:0] SHORT_MAX_CNT = 6'h0A;
    localparam logic [5:0] STATUS_CNT    = 6'h02;

    // Mode encodings.
    localparam logic [3:0] MODE_DISABLED  = 4'h0;
    localparam logic [3:0] MODE_NAK_IO    = 4'h1;
    localparam logic [3:0] MODE_STALL_IO  = 4'h3;
    localparam logic [3:0] MODE_IGNORE_IO = 4'h4;
    localparam logic [3:0] MODE_STAT_IN   = 4'h6;
    localparam logic [3:0] MODE_PREM_STAT = 4'hA;
    localparam logic [3:0] MODE_NORM_OUT  = 4'hB;
    localparam logic [3:0] MODE_STAT_OUTB = 4'hE;
    localparam logic [3:0] MODE_STAT_OUT  = 4'hF;
    localparam logic [3:0] MODE_ACK_OUT   = 4'h9;
    localparam logic [3:0] MODE_ACK_IN    = 4'hD;

    typedef enum logic [1:0] {
        TOK_SETUP = 2'h0,
        TOK_OUT   = 2'h1,
        TOK_IN    = 2'h2
    } usbe_tok_e;

    typedef enum logic [2:0] {
        RESP_IGNORE = 3'h0,
        RESP_ACK    = 3'h1,
        RESP_NAK    = 3'h2,
        RESP_STALL  = 3'h3,
        RESP_ZLP    = 3'h4,
        RESP_DATA   = 3'h5
    } usbe_resp_e;

endpackage
